// File: rtl/lmr_memory_map.sv
// Overview of operation
// RULE1: pages 0-15 are 512 bytes of SRAM
// RULE2: pages 16 and 17 hold the registers; only page 16 is decoded here, page 17 reads zero
// RULE3: pages 18-19 calibration, 19 duplicates 18
// RULE4: last calibration byte is crc of 31
// RULE5: data log from 1000h, 256 pages
// RULE6: pages 20-127 are reserved
// RULE7: host writes go through scratchpad page
// RULE8: data log read only, internal writes only
// RULE9: config registers lock during a mission
// RULE10: host should write whole pages
// RULE11: host should not overwrite calibration
// RULE12: clock registers bcd, zero bits read zero
// RULE13: sample interval 14 bits, zero means one
// RULE14: reserved addresses read zero, ignore writes
`timescale 1ns/1ps
module lmr_memory_map (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [13:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // sensing and mission control logic
    input wire lmr_pkg::lmr_sense_type sense_i,
    input wire logic log_wr_i,
    input wire logic [12:0] log_addr_i,
    input wire logic [7:0] log_data_i,
    // configuration and status
    output lmr_pkg::lmr_cfg_type cfg_o,
    output logic copy_busy_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] sram_mem [512];
    logic [7:0] cal_mem [64];
    logic [7:0] log_mem [8192];
    logic [7:0] regs_ff [lmr_pkg::REG_COUNT];
    logic [7:0] scratch_mem [lmr_pkg::PAGE_BYTES];
    logic [31:0] scr_mask_ff;
    logic [8:0] scr_page_ff;
    lmr_pkg::lmr_state_type state_ff;
    logic [4:0] copy_ix_ff;
    logic [7:0] crc_ff;
    logic [7:0] nxt_crc;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_en_ff;
    logic [2:0] events;
    logic [7:0] rdata_ff;
    logic [7:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    logic [8:0] page;
    logic in_sram;
    logic in_reg1;
    logic in_cal;
    logic in_log;
    logic to_scratch;
    logic [12:0] log_ix;
    logic [4:0] reg_ix;

    assign page = addr_i[13:5];
    assign in_sram = page <= lmr_pkg::PAGE_SRAM_LAST; // RULE1
    assign in_reg1 = page == lmr_pkg::PAGE_REG1; // RULE2
    assign in_cal = (page == lmr_pkg::PAGE_CAL)
                  || (page == lmr_pkg::PAGE_CAL_DUP); // RULE3
    assign in_log = (addr_i >= lmr_pkg::LOG_BASE)
                  && (addr_i < lmr_pkg::LOG_END); // RULE5
    // pages 17 and 20-127 fall through every read decode, page 17 writes still reach the scratchpad // RULE6
    assign to_scratch = addr_i < lmr_pkg::RSV_BASE;
    assign log_ix = 13'(addr_i - lmr_pkg::LOG_BASE);
    assign reg_ix = addr_i[4:0];

    ////////////////////////////////////////////////////////////////////////
    // register field layout
    function automatic logic [7:0] reg_wmask(input logic [4:0] ix);
        case (ix)
            lmr_pkg::REG_SECONDS[4:0], lmr_pkg::REG_MINUTES[4:0],
            lmr_pkg::REG_HOURS[4:0]: reg_wmask = 8'h7F; // RULE12
            lmr_pkg::REG_DATE[4:0]: reg_wmask = 8'h3F; // RULE12
            lmr_pkg::REG_MONTHS[4:0]: reg_wmask = 8'h9F; // RULE12
            lmr_pkg::REG_RATE_HI[4:0]: reg_wmask = 8'h3F; // RULE13
            lmr_pkg::REG_TEMP_ALM_EN[4:0], lmr_pkg::REG_HUMID_ALM_EN[4:0],
            lmr_pkg::REG_CLOCK_CTL[4:0]: reg_wmask = 8'h03;
            lmr_pkg::REG_MISSION_CTL[4:0]: reg_wmask = 8'h3F;
            lmr_pkg::REG_LAT_TEMP_LO[4:0], lmr_pkg::REG_LAT_TEMP_HI[4:0],
            lmr_pkg::REG_LAT_HUMID_LO[4:0], lmr_pkg::REG_LAT_HUMID_HI[4:0],
            lmr_pkg::REG_ALARM_FLAGS[4:0], lmr_pkg::REG_GENERAL[4:0]:
                reg_wmask = 8'h00;
            default: reg_wmask = (ix <= lmr_pkg::REG_DELAY_HI[4:0])
                               ? 8'hFF : 8'h00;
        endcase
    endfunction

    // bits that always read as one
    function automatic logic [7:0] reg_ones(input logic [4:0] ix);
        case (ix)
            lmr_pkg::REG_HUMID_ALM_EN[4:0]: reg_ones = 8'hFC;
            lmr_pkg::REG_MISSION_CTL[4:0]: reg_ones = 8'hC0;
            default: reg_ones = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] reg_read(input logic [4:0] ix,
                                            input lmr_pkg::lmr_sense_type s,
                                            input logic [7:0] stored);
        case (ix)
            lmr_pkg::REG_LAT_TEMP_LO[4:0]:
                reg_read = s.latest_temp[7:0] & 8'hE0;
            lmr_pkg::REG_LAT_TEMP_HI[4:0]: reg_read = s.latest_temp[15:8];
            lmr_pkg::REG_LAT_HUMID_LO[4:0]: reg_read = s.latest_humid[7:0];
            lmr_pkg::REG_LAT_HUMID_HI[4:0]:
                reg_read = s.latest_humid[15:8];
            lmr_pkg::REG_ALARM_FLAGS[4:0]:
                reg_read = {s.bor, 3'h7, s.alarm_flags};
            lmr_pkg::REG_GENERAL[4:0]:
                reg_read = {3'h6, s.wait_temp_alarm, s.mem_cleared, 1'b0,
                            s.mission_active_flag, 1'b0};
            default: reg_read = (stored & reg_wmask(ix)) | reg_ones(ix);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // host write decode
    logic scr_wr;
    logic copy_req;
    logic copy_start;
    logic copy_locked;
    logic refused;

    // the scratchpad cannot change under a running copy
    assign scr_wr = wr_i && to_scratch && (state_ff == lmr_pkg::LMR_IDLE);
    assign copy_req = wr_i && (addr_i == lmr_pkg::CTL_COPY);
    // config pages cannot be committed while a mission runs
    assign copy_locked = (scr_page_ff == lmr_pkg::PAGE_REG1)
                       && sense_i.mission_active_flag; // RULE9
    assign copy_start = copy_req && (state_ff == lmr_pkg::LMR_IDLE)
                      && (scr_mask_ff != 32'h0) && !copy_locked;
    assign refused = (wr_i && in_log) // RULE8
                   || (wr_i && to_scratch && !scr_wr)
                   || (copy_req && !copy_start);

    ////////////////////////////////////////////////////////////////////////
    // scratchpad buffer
    always_ff @(posedge ref_clk_i) begin
        if (scr_wr) begin
            scratch_mem[addr_i[4:0]] <= wdata_i; // RULE7
        end
    end

    // a write to a new page drops the marks of the old one
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scr_mask_ff <= 32'h0;
            scr_page_ff <= 9'h0;
        end else if (scr_wr) begin
            scr_page_ff <= page;
            if (page != scr_page_ff) begin
                scr_mask_ff <= 32'h1 << addr_i[4:0];
            end else begin
                scr_mask_ff <= scr_mask_ff | (32'h1 << addr_i[4:0]);
            end
        end else if (events[lmr_pkg::IRQ_COPY_DONE]) begin
            scr_mask_ff <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // copy sequencer
    logic copy_cal;
    logic copy_byte;
    logic [7:0] copy_data;

    assign copy_cal = (scr_page_ff == lmr_pkg::PAGE_CAL)
                    || (scr_page_ff == lmr_pkg::PAGE_CAL_DUP);
    assign copy_byte = (state_ff == lmr_pkg::LMR_COPY)
                     && scr_mask_ff[copy_ix_ff];
    assign copy_data = scratch_mem[copy_ix_ff];

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= lmr_pkg::LMR_IDLE;
            copy_ix_ff <= 5'h0;
        end else begin
            case (state_ff)
                lmr_pkg::LMR_IDLE: begin
                    copy_ix_ff <= 5'h0;
                    if (copy_start) begin
                        state_ff <= lmr_pkg::LMR_COPY;
                    end
                end
                lmr_pkg::LMR_COPY: begin
                    copy_ix_ff <= copy_ix_ff + 5'h1;
                    if (copy_ix_ff == 5'h1F) begin
                        state_ff <= copy_cal ? lmr_pkg::LMR_CRC
                                             : lmr_pkg::LMR_IDLE;
                    end
                end
                lmr_pkg::LMR_CRC: state_ff <= lmr_pkg::LMR_IDLE;
                default: state_ff <= lmr_pkg::LMR_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general-purpose memory
    always_ff @(posedge ref_clk_i) begin
        if (copy_byte && scr_page_ff <= lmr_pkg::PAGE_SRAM_LAST) begin
            sram_mem[{scr_page_ff[3:0], copy_ix_ff}] <= copy_data; // RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration pages, both copies written together
    logic [7:0] cal_byte;

    assign cal_byte = copy_byte ? copy_data : cal_mem[{1'b0, copy_ix_ff}];

    lmr_crc8 u_crc (
        .crc_i(crc_ff),
        .data_i(cal_byte),
        .crc_o(nxt_crc)
    );

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_ff <= lmr_pkg::CRC_INIT;
        end else if (state_ff == lmr_pkg::LMR_IDLE) begin
            crc_ff <= lmr_pkg::CRC_INIT;
        end else if (state_ff == lmr_pkg::LMR_COPY
                     && copy_ix_ff != lmr_pkg::CAL_CRC_IX) begin
            crc_ff <= nxt_crc; // RULE4
        end
    end

    // the check byte is always rebuilt, host data there is dropped
    always_ff @(posedge ref_clk_i) begin
        if (copy_byte && copy_cal
            && copy_ix_ff != lmr_pkg::CAL_CRC_IX) begin
            cal_mem[{1'b0, copy_ix_ff}] <= copy_data; // RULE3
            cal_mem[{1'b1, copy_ix_ff}] <= copy_data; // RULE3
        end else if (state_ff == lmr_pkg::LMR_CRC) begin
            cal_mem[{1'b0, lmr_pkg::CAL_CRC_IX}] <= crc_ff; // RULE4
            cal_mem[{1'b1, lmr_pkg::CAL_CRC_IX}] <= crc_ff; // RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data log, filled only by the sampling logic
    always_ff @(posedge ref_clk_i) begin
        if (log_wr_i) begin
            log_mem[log_addr_i] <= log_data_i; // RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register page 1
    generate
        for (genvar g = 0; g < lmr_pkg::REG_COUNT; g++) begin : g_reg
            always_ff @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    regs_ff[g] <= lmr_pkg::REG_RESET;
                end else if (copy_byte
                             && scr_page_ff == lmr_pkg::PAGE_REG1
                             && copy_ix_ff == 5'(g)) begin
                    regs_ff[g] <= copy_data & reg_wmask(5'(g)); // RULE12
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, set wins over clear
    assign events[lmr_pkg::IRQ_COPY_DONE] =
        (state_ff == lmr_pkg::LMR_CRC)
        || (state_ff == lmr_pkg::LMR_COPY && copy_ix_ff == 5'h1F
            && !copy_cal);
    assign events[lmr_pkg::IRQ_REFUSED] = refused;
    assign events[lmr_pkg::IRQ_LOG_WR] = log_wr_i;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat_ff <= lmr_pkg::IRQ_RESET;
        end else if (wr_i && addr_i == lmr_pkg::CTL_IRQ_CLEAR) begin
            irq_stat_ff <= (irq_stat_ff & ~wdata_i[2:0]) | events;
        end else begin
            irq_stat_ff <= irq_stat_ff | events;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_en_ff <= lmr_pkg::IRQ_RESET;
        end else if (wr_i && addr_i == lmr_pkg::CTL_IRQ_ENABLE) begin
            irq_en_ff <= wdata_i[2:0];
        end
    end

    assign irq_o = |(irq_stat_ff & irq_en_ff);

    ////////////////////////////////////////////////////////////////////////
    // read path, data valid only in the cycle after the strobe
    always_comb begin
        rd_val = 8'h00; // RULE14
        if (in_sram) begin
            rd_val = sram_mem[addr_i[8:0]];
        end else if (in_reg1) begin
            rd_val = reg_read(reg_ix, sense_i, regs_ff[reg_ix]); // RULE2
        end else if (in_cal) begin
            rd_val = cal_mem[addr_i[5:0]];
        end else if (in_log) begin
            rd_val = log_mem[log_ix];
        end else if (addr_i == lmr_pkg::CTL_IRQ_STATUS) begin
            rd_val = {5'h0, irq_stat_ff};
        end else if (addr_i == lmr_pkg::CTL_IRQ_ENABLE) begin
            rd_val = {5'h0, irq_en_ff};
        end else if (addr_i == lmr_pkg::CTL_TARGET) begin
            rd_val = {copy_busy_o, scr_page_ff[6:0]};
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= 8'h00;
        end else if (rd_i) begin
            rdata_ff <= rd_val;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata_o = rdata_ff;
    assign copy_busy_o = state_ff != lmr_pkg::LMR_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // configuration handed to the sampling logic
    logic [13:0] raw_interval;

    assign raw_interval = {regs_ff[lmr_pkg::REG_RATE_HI[4:0]][5:0],
                           regs_ff[lmr_pkg::REG_RATE_LO[4:0]]};

    always_comb begin
        cfg_o.seconds = regs_ff[lmr_pkg::REG_SECONDS[4:0]];
        cfg_o.minutes = regs_ff[lmr_pkg::REG_MINUTES[4:0]];
        cfg_o.hours = regs_ff[lmr_pkg::REG_HOURS[4:0]];
        cfg_o.date = regs_ff[lmr_pkg::REG_DATE[4:0]];
        cfg_o.months = regs_ff[lmr_pkg::REG_MONTHS[4:0]];
        cfg_o.years = regs_ff[lmr_pkg::REG_YEARS[4:0]];
        // a zero interval would stall sampling forever
        cfg_o.sample_interval = (raw_interval == 14'h0000)
                              ? 14'h0001 : raw_interval; // RULE13
        cfg_o.temp_lo_th = regs_ff[lmr_pkg::REG_TEMP_LO_TH[4:0]];
        cfg_o.temp_hi_th = regs_ff[lmr_pkg::REG_TEMP_HI_TH[4:0]];
        cfg_o.humid_lo_th = regs_ff[lmr_pkg::REG_HUMID_LO_TH[4:0]];
        cfg_o.humid_hi_th = regs_ff[lmr_pkg::REG_HUMID_HI_TH[4:0]];
        cfg_o.temp_alarm_en = regs_ff[lmr_pkg::REG_TEMP_ALM_EN[4:0]][1:0];
        cfg_o.humid_alarm_en =
            regs_ff[lmr_pkg::REG_HUMID_ALM_EN[4:0]][1:0];
        cfg_o.high_speed_sample = regs_ff[lmr_pkg::REG_CLOCK_CTL[4:0]][1];
        cfg_o.osc_enable = regs_ff[lmr_pkg::REG_CLOCK_CTL[4:0]][0];
        cfg_o.mission_ctl = regs_ff[lmr_pkg::REG_MISSION_CTL[4:0]][5:0];
        cfg_o.start_delay = {regs_ff[lmr_pkg::REG_DELAY_HI[4:0]],
                             regs_ff[lmr_pkg::REG_DELAY_MID[4:0]],
                             regs_ff[lmr_pkg::REG_DELAY_LO[4:0]]};
    end

endmodule

// File: rtl/lmr_pkg.sv
package lmr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // linear address space
    localparam int ADDR_W = 14;
    localparam int PAGE_BYTES = 32;
    localparam logic [13:0] SRAM_BASE = 14'h0000;
    localparam logic [13:0] REG_BASE = 14'h0200;
    localparam logic [13:0] REG2_BASE = 14'h0220;
    localparam logic [13:0] CAL_BASE = 14'h0240;
    localparam logic [13:0] CAL_DUP_BASE = 14'h0260;
    localparam logic [13:0] RSV_BASE = 14'h0280;
    localparam logic [13:0] LOG_BASE = 14'h1000;
    localparam logic [13:0] LOG_END = 14'h3000;
    localparam logic [8:0] PAGE_SRAM_LAST = 9'h00F;
    localparam logic [8:0] PAGE_REG1 = 9'h010;
    localparam logic [8:0] PAGE_REG2 = 9'h011;
    localparam logic [8:0] PAGE_CAL = 9'h012;
    localparam logic [8:0] PAGE_CAL_DUP = 9'h013;
    localparam logic [4:0] CAL_CRC_IX = 5'h1F;

    ////////////////////////////////////////////////////////////////////////
    // register page 1
    localparam logic [13:0] REG_SECONDS = 14'h0200;
    localparam logic [13:0] REG_MINUTES = 14'h0201;
    localparam logic [13:0] REG_HOURS = 14'h0202;
    localparam logic [13:0] REG_DATE = 14'h0203;
    localparam logic [13:0] REG_MONTHS = 14'h0204;
    localparam logic [13:0] REG_YEARS = 14'h0205;
    localparam logic [13:0] REG_RATE_LO = 14'h0206;
    localparam logic [13:0] REG_RATE_HI = 14'h0207;
    localparam logic [13:0] REG_TEMP_LO_TH = 14'h0208;
    localparam logic [13:0] REG_TEMP_HI_TH = 14'h0209;
    localparam logic [13:0] REG_HUMID_LO_TH = 14'h020A;
    localparam logic [13:0] REG_HUMID_HI_TH = 14'h020B;
    localparam logic [13:0] REG_LAT_TEMP_LO = 14'h020C;
    localparam logic [13:0] REG_LAT_TEMP_HI = 14'h020D;
    localparam logic [13:0] REG_LAT_HUMID_LO = 14'h020E;
    localparam logic [13:0] REG_LAT_HUMID_HI = 14'h020F;
    localparam logic [13:0] REG_TEMP_ALM_EN = 14'h0210;
    localparam logic [13:0] REG_HUMID_ALM_EN = 14'h0211;
    localparam logic [13:0] REG_CLOCK_CTL = 14'h0212;
    localparam logic [13:0] REG_MISSION_CTL = 14'h0213;
    localparam logic [13:0] REG_ALARM_FLAGS = 14'h0214;
    localparam logic [13:0] REG_GENERAL = 14'h0215;
    localparam logic [13:0] REG_DELAY_LO = 14'h0216;
    localparam logic [13:0] REG_DELAY_MID = 14'h0217;
    localparam logic [13:0] REG_DELAY_HI = 14'h0218;
    localparam int REG_COUNT = 25;
    localparam logic [7:0] REG_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // block control registers
    localparam logic [13:0] CTL_COPY = 14'h3000;
    localparam logic [13:0] CTL_IRQ_STATUS = 14'h3001;
    localparam logic [13:0] CTL_IRQ_CLEAR = 14'h3002;
    localparam logic [13:0] CTL_IRQ_ENABLE = 14'h3003;
    localparam logic [13:0] CTL_TARGET = 14'h3004;
    localparam int IRQ_W = 3;
    localparam int IRQ_COPY_DONE = 0;
    localparam int IRQ_REFUSED = 1;
    localparam int IRQ_LOG_WR = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // check byte, x^8+x^5+x^4+1 shifted lsb first
    localparam logic [7:0] CRC_POLY = 8'h8C;
    localparam logic [7:0] CRC_INIT = 8'h00;

    typedef enum logic [1:0] {
        LMR_IDLE,
        LMR_COPY,
        LMR_CRC
    } lmr_state_type;

    typedef struct packed {
        logic [15:0] latest_temp;
        logic [15:0] latest_humid;
        logic bor;
        logic [3:0] alarm_flags;
        logic mission_active_flag;
        logic wait_temp_alarm;
        logic mem_cleared;
    } lmr_sense_type;

    typedef struct packed {
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] date;
        logic [7:0] months;
        logic [7:0] years;
        logic [13:0] sample_interval;
        logic [7:0] temp_lo_th;
        logic [7:0] temp_hi_th;
        logic [7:0] humid_lo_th;
        logic [7:0] humid_hi_th;
        logic [1:0] temp_alarm_en;
        logic [1:0] humid_alarm_en;
        logic high_speed_sample;
        logic osc_enable;
        logic [5:0] mission_ctl;
        logic [23:0] start_delay;
    } lmr_cfg_type;

endpackage

// File: rtl/lmr_crc8.sv
`timescale 1ns/1ps
module lmr_crc8 (
    // running check value and new byte
    input wire logic [7:0] crc_i,
    input wire logic [7:0] data_i,
    // updated check value
    output logic [7:0] crc_o
);
    always_comb begin
        logic [7:0] c;
        c = crc_i;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ data_i[i]) begin
                c = (c >> 1) ^ lmr_pkg::CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        crc_o = c;
    end
endmodule

// File: verif/lmr_sense_model.sv
`timescale 1ns/1ps
module lmr_sense_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // bench control
    input wire logic mission_i,
    input wire logic log_go_i,
    // sensing side of the map
    output lmr_pkg::lmr_sense_type sense_o,
    output logic log_wr_o,
    output logic [12:0] log_addr_o,
    output logic [7:0] log_data_o
);
    logic [7:0] cnt_ff;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_ff <= 8'h00;
            log_wr_o <= 1'b0;
            log_addr_o <= 13'h0000;
            log_data_o <= 8'h00;
        end else begin
            // only this side fills the log, near its top end
            log_wr_o <= log_go_i;
            log_addr_o <= {5'h1F, cnt_ff};
            log_data_o <= cnt_ff ^ 8'hA5;
            if (log_go_i) cnt_ff <= cnt_ff + 8'h01;
        end
    end
    always_comb begin
        sense_o = '0;
        sense_o.mission_active_flag = mission_i;
        sense_o.alarm_flags = cnt_ff[3:0];
        sense_o.bor = cnt_ff[0];
    end
endmodule

// File: verif/lmr_memory_map_sva.sv
`timescale 1ns/1ps
module lmr_map_chk (
    // clock, reset, register port
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [13:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // sensing side and outputs
    input wire lmr_pkg::lmr_sense_type sense_i,
    input wire logic log_wr_i,
    input wire logic [12:0] log_addr_i,
    input wire logic [7:0] log_data_i,
    input wire lmr_pkg::lmr_cfg_type cfg_o,
    input wire logic copy_busy_o,
    input wire logic irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_rsv;
        rd_i && addr_i >= lmr_pkg::RSV_BASE && addr_i < lmr_pkg::LOG_BASE
        |=> rdata_o == 8'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved read nonzero");
    property p_sec;
        rd_i && addr_i == lmr_pkg::REG_SECONDS |=> !rdata_o[7];
    endproperty
    a_sec: assert property (p_sec) else $error("seconds bit7 set");
    property p_hum;
        rd_i && addr_i == lmr_pkg::REG_HUMID_ALM_EN |=> rdata_o[7:2] == 6'h3F;
    endproperty
    a_hum: assert property (p_hum) else $error("alarm enable ones");
    property p_rate;
        cfg_o.sample_interval != 14'h0000;
    endproperty
    a_rate: assert property (p_rate) else $error("interval is zero");
    property p_alarm;
        rd_i && addr_i == lmr_pkg::REG_ALARM_FLAGS |=> rdata_o ==
        {$past(sense_i.bor), 3'b111, $past(sense_i.alarm_flags)};
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm byte");
    property p_mip;
        rd_i && addr_i == lmr_pkg::REG_GENERAL
        |=> rdata_o[1] == $past(sense_i.mission_active_flag);
    endproperty
    a_mip: assert property (p_mip) else $error("mission flag read");
    // one page walk, plus one crc cycle for calibration
    property p_copy;
        $rose(copy_busy_o) |-> copy_busy_o [*8] ##[25:26] !copy_busy_o;
    endproperty
    a_copy: assert property (p_copy) else $error("copy length");
    property p_log;
        logic [7:0] d;
        logic [12:0] a;
        (log_wr_i, d = log_data_i, a = log_addr_i) ##1 (rd_i && !log_wr_i
        && addr_i == 14'h1000 + {1'b0, a}) |=> rdata_o == d;
    endproperty
    a_log: assert property (p_log) else $error("log byte lost");
    c_copy: cover property ($fell(copy_busy_o));
    c_irq: cover property ($rose(irq_o));
    c_log: cover property (log_wr_i ##1 rd_i);
endmodule
bind lmr_memory_map lmr_map_chk chk_u (.*);

// File: verif/test_logger_memory_map_register_pages.sv
`timescale 1ns/1ps
module test_logger_memory_map_register_pages;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [13:0] addr_i = 14'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic mission = 1'b0;
    logic log_go = 1'b0;
    logic [7:0] rdata_o, log_data, got, t8;
    logic [12:0] log_addr;
    logic log_wr, copy_busy_o, irq_o;
    lmr_pkg::lmr_sense_type sense;
    lmr_pkg::lmr_cfg_type cfg_o;
    int num_errors = 0;
    int n_tests = 0;
    integer seed = 32'hACA0;
    logic [7:0] pg [32];
    logic [13:0] p;
    always #4 ref_clk_i = ~ref_clk_i;
    lmr_sense_model model_u (.ref_clk_i, .resetn_i, .mission_i(mission),
        .log_go_i(log_go), .sense_o(sense), .log_wr_o(log_wr),
        .log_addr_o(log_addr), .log_data_o(log_data));
    lmr_memory_map dut_u (.ref_clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .sense_i(sense), .log_wr_i(log_wr),
        .log_addr_i(log_addr), .log_data_i(log_data), .cfg_o, .copy_busy_o,
        .irq_o);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
    endtask
    // whole pages only, random contents
    task automatic fill(input logic [13:0] base);
        for (int k = 0; k < 32; k++) begin
            pg[k] = 8'($random(seed));
            wr(base + 14'(k), pg[k]);
        end
    endtask
    task automatic copy_wait;
        wr(lmr_pkg::CTL_COPY, 8'h00);
        for (int i = 0; i < 41; i++) begin
            @(posedge ref_clk_i);
            #1;
            if (i == 40) begin
                num_errors++;
                report_and_stop;
            end
            if (i > 0 && copy_busy_o === 1'b0) break;
        end
    endtask
    function automatic logic [7:0] crc_of(input int n);
        logic [7:0] c = 8'h00;
        for (int k = 0; k < n; k++)
            for (int b = 0; b < 8; b++)
                c = (c[0] ^ pg[k][b]) ? (c >> 1) ^ 8'h8C : c >> 1;
        return c;
    endfunction
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd(lmr_pkg::REG_HUMID_ALM_EN);
        chk(got, 8'hFC);
        chk(cfg_o.sample_interval, 14'h0001);
        p = {5'h00, 4'($random(seed)), 5'h00};
        fill(p);
        copy_wait;
        for (int k = 0; k < 32; k++) begin
            rd(p + 14'(k));
            chk(got, pg[k]);
        end
        $display("test 1 done");
        fill(lmr_pkg::REG_BASE);
        wr(lmr_pkg::REG_RATE_LO, 8'h00);
        wr(lmr_pkg::REG_RATE_HI, 8'h00);
        chk(cfg_o.seconds, 8'h00);
        copy_wait;
        t8 = pg[8];
        chk(cfg_o.sample_interval, 14'h0001);
        rd(lmr_pkg::REG_SECONDS);
        chk(got, pg[0] & 8'h7F);
        rd(lmr_pkg::REG_TEMP_LO_TH);
        chk(got, t8);
        $display("test 2 done");
        // mission: page copy refused, raises the refused interrupt
        mission <= 1'b1;
        wr(lmr_pkg::CTL_IRQ_ENABLE, 8'h02);
        fill(lmr_pkg::REG_BASE);
        copy_wait;
        chk(irq_o, 1'b1);
        rd(lmr_pkg::REG_TEMP_LO_TH);
        chk(got, t8);
        wr(lmr_pkg::CTL_IRQ_CLEAR, 8'h02);
        #1 chk(irq_o, 1'b0);
        mission <= 1'b0;
        $display("test 3 done");
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk_i);
            log_go <= 1'b1;
            @(posedge ref_clk_i);
            log_go <= 1'b0;
            rd(14'h2F00 + 14'(i));
            chk(got, 8'(i) ^ 8'hA5);
        end
        wr(14'h2F05, 8'h5A);
        #1 chk(irq_o, 1'b1);
        rd(14'h2F05);
        chk(got, 8'hA0);
        wr(14'h0300, 8'h77);
        rd(14'h0300);
        chk(got, 8'h00);
        rd(14'h0FFF);
        chk(got, 8'h00);
        $display("test 4 done");
        fill(lmr_pkg::CAL_BASE);
        copy_wait;
        for (int k = 0; k < 31; k++) begin
            rd(lmr_pkg::CAL_DUP_BASE + 14'(k));
            chk(got, pg[k]);
        end
        rd(lmr_pkg::CAL_BASE + 14'h001F);
        chk(got, crc_of(31));
        rd(lmr_pkg::CAL_DUP_BASE + 14'h001F);
        chk(got, crc_of(31));
        $display("test 5 done");
        report_and_stop;
    end
endmodule
